// ==== ssp_cfg.svh ====
/*
  Register offsets, field positions, reset values and divider counts
  of the synchronous serial port. Assumes a 12-bit byte address space.
*/
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SSP_ADDR_BUF0 12'hF90
`define SSP_ADDR_MAIN 12'hF98
`define SSP_ADDR_CFG 12'hF99
// ----------------------------------------
// field positions
// ----------------------------------------
`define SSP_START_BIT 7
`define SSP_ABORT_BIT 6
`define SSP_MODE_HI 5
`define SSP_MODE_LO 3
`define SSP_SCK_HI 2
`define SSP_SCK_LO 0
`define SSP_WAIT_HI 4
`define SSP_WAIT_LO 3
`define SSP_COUNT_HI 2
`define SSP_COUNT_LO 0
`define SSP_STAT_XFER 7
`define SSP_STAT_SHIFT 6
// ----------------------------------------
// reset values
// ----------------------------------------
`define SSP_MAIN_RST 8'h00
`define SSP_CFG_RST 8'h00
// ----------------------------------------
// serial clock half periods in ref_clk cycles; frame gap unit in serial clock half periods
// ----------------------------------------
`define SSP_HALF_SEL0 13'h1000
`define SSP_HALF_SEL1 13'h0080
`define SSP_HALF_SEL2 13'h0040
`define SSP_HALF_SEL3 13'h0020
`define SSP_HALF_SEL4 13'h0010
`define SSP_HALF_SEL5 13'h0008
`define SSP_SLOW_HALF_DEF 4096
`define SSP_GAP_UNIT 7'h10
`endif

// ==== ssp_pkg.sv ====
/*
  Types of the synchronous serial port.
  Assumes ssp_cfg.svh carries all numeric constants.
*/
package ssp_pkg;
  typedef logic [11:0] ssp_addr_t;
  typedef logic [7:0] ssp_byte_t;
  typedef enum logic [2:0] {
    SSP_TX8 = 3'b000,
    SSP_TX4 = 3'b010,
    SSP_TXRX8 = 3'b100,
    SSP_RX8 = 3'b101,
    SSP_RX4 = 3'b110
  } ssp_mode_e;
  typedef enum logic [2:0] {
    SSP_CLK_SLOW = 3'b000,
    SSP_CLK_RSVD = 3'b110,
    SSP_CLK_EXT = 3'b111
  } ssp_clk_e;
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_SHIFT = 2'b01,
    SSP_GAP = 2'b10,
    SSP_HOLD = 2'b11
  } ssp_state_e;
endpackage

// ==== ssp_buf_if.sv ====
/*
  Interface between the serial core and its eight-entry data buffer.
  Assumes one clock; read data are combinational.
*/
interface ssp_buf_if;
  logic swWr;
  logic [2:0] swIdx;
  logic [7:0] swWdata;
  logic [7:0] swRdata;
  logic coreWr;
  logic [2:0] coreIdx;
  logic [7:0] coreWdata;
  logic [7:0] coreRdata;
  modport core (output swWr, swIdx, swWdata, coreWr, coreIdx, coreWdata,
                input swRdata, coreRdata);
  modport store (input swWr, swIdx, swWdata, coreWr, coreIdx, coreWdata,
                 output swRdata, coreRdata);
endinterface

// ==== ssp_data_buffer.sv ====
/*
  Eight-entry data buffer, flip-flop storage addressed by index.
  Assumes software and core never write the same cycle in normal use.
*/
module ssp_data_buffer (
  input wire logic ref_clk,
  input wire logic rst,
  ssp_buf_if.store bus
);
  import ssp_pkg::*;
  ssp_byte_t entry [8];

  assign bus.swRdata = entry[bus.swIdx];
  assign bus.coreRdata = entry[bus.coreIdx];

  // software write wins a collision: the core word is then stale anyway
  for (genvar i = 0; i < 8; i++) begin : gEntry
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        entry[i] <= 8'h00;
      end else if (bus.swWr && bus.swIdx == i) begin
        entry[i] <= bus.swWdata;
      end else if (bus.coreWr && bus.coreIdx == i) begin
        entry[i] <= bus.coreWdata;
      end
    end
  end
endmodule

// ==== ssp_clock_gen.sv ====
/*
  Internal serial clock divider: one tick per half period.
  Assumes run drops whenever the clock must stand still.
*/
`include "ssp_cfg.svh"
module ssp_clock_gen #(
  parameter int SLOW_HALF = `SSP_SLOW_HALF_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] clkSel,
  input wire logic altSel,
  input wire logic slowMode,
  output logic tick
);
  import ssp_pkg::*;
  logic [12:0] count;
  wire [12:0] half;

  function automatic logic [12:0] halfOf(input logic [2:0] s, input logic alt,
                                         input logic slow);
    halfOf = `SSP_HALF_SEL0;
    case (s)
      3'b000: halfOf = (alt || slow) ? 13'(SLOW_HALF) : `SSP_HALF_SEL0;
      3'b001: halfOf = `SSP_HALF_SEL1;
      3'b010: halfOf = `SSP_HALF_SEL2;
      3'b011: halfOf = `SSP_HALF_SEL3;
      3'b100: halfOf = `SSP_HALF_SEL4;
      3'b101: halfOf = `SSP_HALF_SEL5;
      default: halfOf = `SSP_HALF_SEL0;
    endcase
  endfunction

  assign half = halfOf(clkSel, altSel, slowMode);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= 13'h0000;
      tick <= 1'b0;
    end else begin
      tick <= run && (count == half - 13'h0001);
      count <= (!run || count == half - 13'h0001) ? 13'h0000 : count + 13'h0001;
    end
  end
endmodule

// ==== ssp_sync_serial.sv ====
/*
  Synchronous serial port: register slave, shift engine with buffer
  sequencing, automatic wait and completion pulse.
  Assumes a single-cycle register port and an outside peripheral on
  the serial clock and data pins.
*/
`include "ssp_cfg.svh"
// Function
// - 3-bit word count, 000 one word up to 111 eight words.
// - 4-bit transfers use low nibble; received upper nibble is zero.
// - transmit and receive walk the buffer upward from entry zero.
// - programmed word count is kept after a transfer ends.
// - status bit 7 shows transfer active, bit 6 shift active.
// - transfer flag clears at stop completion, or at once on abort.
// - internal clock drives the clock pin, high at transfer start.
// - clock select picks divider rates, reserved code, or external clock.
// - internal clock stops until software services the buffer.
// - transmit data change on the falling clock pin edge.
// - receive data are sampled on the rising clock pin edge.
// - each word goes least significant bit first.
// - completion interrupt after the programmed number of words.
// - word count may change during automatic wait without stopping.
// - mode codes 000,010,100,101,110 are legal; others reserved.
// - start bit runs and stops; abort ends and clears itself.
module ssp_sync_serial #(
  parameter int SLOW_HALF = `SSP_SLOW_HALF_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ssp_pkg::ssp_addr_t regAddr,
  input wire ssp_pkg::ssp_byte_t regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output ssp_pkg::ssp_byte_t regRdata,
  input wire logic dividerAltSelect,
  input wire logic slowMode,
  input wire logic sckIn,
  input wire logic serialIn,
  output logic sckOut,
  output logic sckOe,
  output logic serialOut,
  output logic serialDoneInterrupt
);
  import ssp_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic startBit;
  logic abortBit;
  logic [2:0] mode;
  logic [2:0] clkSel;
  logic [2:0] wordCount;
  logic [2:0] wordIdx;
  logic [1:0] waitCode;
  ssp_state_e state;
  ssp_state_e next_state;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [7:0] txShift;
  logic [7:0] next_txShift;
  logic [7:0] rxShift;
  logic [7:0] next_rxShift;
  logic [6:0] gapCnt;
  logic [6:0] next_gapCnt;
  logic [2:0] next_wordIdx;
  logic xferActive;
  logic next_xferActive;
  logic shiftActive;
  logic serviced;
  logic next_serviced;
  logic next_sckOut;
  logic next_serialOut;
  logic next_irq;
  logic hwClearStart;
  logic hwClearAbort;
  logic coreWr;
  logic [7:0] coreWdata;
  logic [7:0] cur;
  logic [7:0] newRx;
  logic consume;
  logic sck1;
  logic sck2;
  logic sckPrev;
  logic si1;
  logic si2;
  logic tick;
  logic extClk;

  ssp_buf_if bufBus ();

  ssp_data_buffer uBuf (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus(bufBus)
  );

  ssp_clock_gen #(.SLOW_HALF(SLOW_HALF)) uClk (
    .ref_clk(ref_clk),
    .rst(rst),
    .run((state == SSP_SHIFT || state == SSP_GAP) && !extClk),
    .clkSel(clkSel),
    .altSel(dividerAltSelect),
    .slowMode(slowMode),
    .tick(tick)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic inBuf(input ssp_addr_t a);
    inBuf = (a[11:3] == 9'(`SSP_ADDR_BUF0 >> 3));
  endfunction

  wire mainWr = regWr && regAddr == `SSP_ADDR_MAIN;
  wire cfgWr = regWr && regAddr == `SSP_ADDR_CFG;
  wire bufWr = regWr && inBuf(regAddr);
  wire bufRd = regRd && inBuf(regAddr);
  wire modeLegal = mode == SSP_TX8 || mode == SSP_TX4 || mode == SSP_TXRX8 ||
                   mode == SSP_RX8 || mode == SSP_RX4;
  wire isTx = mode == SSP_TX8 || mode == SSP_TX4 || mode == SSP_TXRX8;
  wire isRx = mode == SSP_TXRX8 || mode == SSP_RX8 || mode == SSP_RX4;
  wire is4 = mode == SSP_TX4 || mode == SSP_RX4;
  assign extClk = clkSel == SSP_CLK_EXT;
  wire clkLegal = clkSel != SSP_CLK_RSVD;
  wire [3:0] lastBit = is4 ? 4'h3 : 4'h7;
  // transmit-capable modes are serviced by a write, receive-only by a read
  wire svcEv = isTx ? bufWr : bufRd;
  wire inShift = state == SSP_SHIFT;
  wire fallEv = inShift && (extClk ? (sckPrev && !sck2) : (tick && sckOut));
  wire riseEv = inShift && (extClk ? (!sckPrev && sck2) : (tick && !sckOut));
  wire wordDone = riseEv && bitCnt == lastBit;
  wire lastWord = wordIdx == wordCount;
  // frame wait only shapes an internal clock
  wire needGap = waitCode != 2'b00 && !extClk;
  wire [6:0] gapLoad = waitCode == 2'b01 ? `SSP_GAP_UNIT :
                       waitCode == 2'b10 ? 7'(3 * `SSP_GAP_UNIT) :
                       7'(7 * `SSP_GAP_UNIT);
  ssp_state_e resumeState;
  assign resumeState = needGap ? SSP_GAP : SSP_SHIFT;
  wire [7:0] statusByte = {xferActive, shiftActive, 6'h00};
  wire [7:0] readMux = inBuf(regAddr) ? bufBus.swRdata :
                       regAddr == `SSP_ADDR_CFG ? statusByte : 8'h00;

  assign bufBus.swWr = bufWr;
  assign bufBus.swIdx = regAddr[2:0];
  assign bufBus.swWdata = regWdata;
  assign bufBus.coreWr = coreWr;
  assign bufBus.coreIdx = wordIdx;
  assign bufBus.coreWdata = coreWdata;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_bitCnt = bitCnt;
    next_txShift = txShift;
    next_rxShift = rxShift;
    next_gapCnt = gapCnt;
    next_wordIdx = wordIdx;
    next_xferActive = xferActive;
    next_sckOut = sckOut;
    next_serialOut = serialOut;
    next_irq = 1'b0;
    hwClearStart = 1'b0;
    hwClearAbort = 1'b0;
    coreWr = 1'b0;
    consume = 1'b0;
    cur = (bitCnt == 4'h0) ? bufBus.coreRdata : txShift;
    newRx = {si2, rxShift[7:1]};
    // a 4-bit word lands in the upper nibble of the shifter
    coreWdata = is4 ? {4'h0, newRx[7:4]} : newRx;
    if (abortBit) begin
      next_state = SSP_IDLE;
      next_xferActive = 1'b0;
      next_sckOut = 1'b1;
      next_bitCnt = 4'h0;
      hwClearAbort = 1'b1;
    end else begin
      unique case (state)
        SSP_IDLE: begin
          if (startBit && modeLegal && clkLegal) begin
            next_state = SSP_SHIFT;
            next_xferActive = 1'b1;
            next_sckOut = 1'b1;
            next_wordIdx = 3'h0;
            next_bitCnt = 4'h0;
          end
        end
        SSP_SHIFT: begin
          if (fallEv) begin
            // an outside clock leaves the pin latch high
            next_sckOut = extClk;
            next_serialOut = isTx ? cur[0] : 1'b1;
            next_txShift = {1'b0, cur[7:1]};
          end
          if (riseEv) begin
            next_sckOut = 1'b1;
            next_rxShift = newRx;
            next_bitCnt = bitCnt + 4'h1;
          end
          if (wordDone) begin
            next_bitCnt = 4'h0;
            coreWr = isRx;
            next_gapCnt = gapLoad;
            if (!startBit) begin
              next_state = SSP_IDLE;
              next_xferActive = 1'b0;
            end else if (lastWord) begin
              next_irq = 1'b1;
              if (serviced || svcEv) begin
                consume = 1'b1;
                next_wordIdx = 3'h0;
                next_state = resumeState;
              end else if (extClk) begin
                // nothing to hand over: an outside clock cannot be held
                next_state = SSP_IDLE;
                next_xferActive = 1'b0;
                hwClearStart = 1'b1;
              end else begin
                next_state = SSP_HOLD;
              end
            end else begin
              next_wordIdx = wordIdx + 3'h1;
              next_state = resumeState;
            end
          end
        end
        SSP_GAP: begin
          if (tick) begin
            next_gapCnt = gapCnt - 7'h01;
            if (gapCnt == 7'h01) begin
              next_state = SSP_SHIFT;
            end
          end
        end
        SSP_HOLD: begin
          // live count is read on resume, so a rewrite here takes effect
          if (!startBit) begin
            next_state = SSP_IDLE;
            next_xferActive = 1'b0;
          end else if (svcEv) begin
            consume = 1'b1;
            next_wordIdx = 3'h0;
            next_gapCnt = gapLoad;
            next_state = resumeState;
          end
        end
      endcase
    end
    // a service event landing with the consume is kept for the next block
    next_serviced = consume ? (serviced && svcEv) : (serviced || svcEv);
    if (next_state == SSP_IDLE) begin
      next_serviced = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      startBit <= 1'(`SSP_MAIN_RST >> `SSP_START_BIT);
      abortBit <= 1'b0;
      mode <= 3'h0;
      clkSel <= 3'h0;
    end else if (mainWr) begin
      startBit <= regWdata[`SSP_START_BIT];
      abortBit <= regWdata[`SSP_ABORT_BIT];
      mode <= regWdata[`SSP_MODE_HI:`SSP_MODE_LO];
      clkSel <= regWdata[`SSP_SCK_HI:`SSP_SCK_LO];
    end else begin
      startBit <= startBit && !hwClearStart;
      abortBit <= abortBit && !hwClearAbort;
    end
  end

  // count is only ever changed by software
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      waitCode <= 2'h0;
      wordCount <= 3'h0;
    end else if (cfgWr) begin
      waitCode <= regWdata[`SSP_WAIT_HI:`SSP_WAIT_LO];
      wordCount <= regWdata[`SSP_COUNT_HI:`SSP_COUNT_LO];
    end
  end

  // pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck1 <= 1'b1;
      sck2 <= 1'b1;
      sckPrev <= 1'b1;
      si1 <= 1'b0;
      si2 <= 1'b0;
    end else begin
      sck1 <= sckIn;
      sck2 <= sck1;
      sckPrev <= sck2;
      si1 <= serialIn;
      si2 <= si1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= SSP_IDLE;
      bitCnt <= 4'h0;
      txShift <= 8'h00;
      rxShift <= 8'h00;
      gapCnt <= 7'h00;
      wordIdx <= 3'h0;
      xferActive <= 1'b0;
      shiftActive <= 1'b0;
      serviced <= 1'b0;
    end else begin
      state <= next_state;
      bitCnt <= next_bitCnt;
      txShift <= next_txShift;
      rxShift <= next_rxShift;
      gapCnt <= next_gapCnt;
      wordIdx <= next_wordIdx;
      xferActive <= next_xferActive;
      shiftActive <= next_state == SSP_SHIFT;
      serviced <= next_serviced;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sckOut <= 1'b1;
      sckOe <= 1'b0;
      serialOut <= 1'b1;
      serialDoneInterrupt <= 1'b0;
      regRdata <= 8'h00;
    end else begin
      sckOut <= next_sckOut;
      sckOe <= !extClk && clkLegal;
      serialOut <= next_serialOut;
      serialDoneInterrupt <= next_irq;
      regRdata <= regRd ? readMux : 8'h00;
    end
  end
endmodule

// ==== ssp_sync_serial_properties.sv ====
/*
  Port checker of the synchronous serial port, bound to its top.
  Assumes ssp_cfg.svh and ssp_pkg are compiled first.
*/
`include "ssp_cfg.svh"
module ssp_sync_serial_properties #(
  parameter int SLOW_HALF = `SSP_SLOW_HALF_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ssp_pkg::ssp_addr_t regAddr,
  input wire ssp_pkg::ssp_byte_t regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire ssp_pkg::ssp_byte_t regRdata,
  input wire logic dividerAltSelect,
  input wire logic slowMode,
  input wire logic sckIn,
  input wire logic serialIn,
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic serialOut,
  input wire logic serialDoneInterrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssp_pkg::*;
  // ----
  // decoded bus events
  // ----
  wire wrMain = regWr && regAddr == `SSP_ADDR_MAIN;
  wire rdCfg = regRd && regAddr == `SSP_ADDR_CFG;
  wire startOk = wrMain && regWdata[7:6] == 2'b10 && regWdata[2:0] != 3'b110
    && regWdata[5:3] inside {3'b000, 3'b010, 3'b100, 3'b101, 3'b110};
  wire abortWr = wrMain && regWdata[7:6] == 2'b01;
  wire intSel = regWdata[2:0] < 3'b110;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its slot");
  a_status_low: assert property ($past(rdCfg) |-> regRdata[5:0] == 6'h00)
    else $error("status low bits not zero");
  a_unmapped_read: assert property ($past(regRd) && ($past(regAddr) < `SSP_ADDR_BUF0
    || $past(regAddr) > `SSP_ADDR_CFG) |-> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_start_status: assert property (startOk ##[1:2] rdCfg |=> regRdata[7])
    else $error("start did not raise transfer flag");
  a_abort_clears: assert property (abortWr ##[1:2] rdCfg |=> regRdata[7:6] == 2'b00)
    else $error("abort left status set");
  a_irq_pulse: assert property (serialDoneInterrupt |=> !serialDoneInterrupt)
    else $error("interrupt longer than one cycle");
  a_irq_sck_high: assert property (serialDoneInterrupt && sckOe |-> sckOut)
    else $error("interrupt before last rising edge");
  a_sck_idle_high: assert property (!sckOe |-> sckOut)
    else $error("clock pin low while not driven");
  a_oe_follows_sel: assert property (wrMain |-> ##2 sckOe == $past(intSel, 2))
    else $error("clock enable does not follow select");
  a_data_at_fall: assert property ($changed(serialOut) && !sckOut |-> $fell(sckOut))
    else $error("data changed away from falling edge");
  c_irq: cover property (serialDoneInterrupt);
  c_start: cover property (startOk);
  c_shift_low: cover property (sckOe && !sckOut);
endmodule

bind ssp_sync_serial ssp_sync_serial_properties #(.SLOW_HALF(SLOW_HALF)) u_props (
  .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .dividerAltSelect(dividerAltSelect),
  .slowMode(slowMode), .sckIn(sckIn), .serialIn(serialIn), .sckOut(sckOut),
  .sckOe(sckOe), .serialOut(serialOut), .serialDoneInterrupt(serialDoneInterrupt));

// ==== ssp_peripheral_model.sv ====
/*
  Outside peripheral on the serial pins: shifts a stream out and
  captures the port's data, both least significant bit first.
  Assumes the bench resolves the clock pin level.
*/
module ssp_peripheral_model (
  input wire logic sckLine,
  input wire logic serialOut,
  input wire logic clr,
  input wire logic [15:0] txStream,
  output logic serialIn,
  output logic [15:0] capWord,
  output logic [4:0] capCnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] stream;
  logic bitReg = 1'b1;
  logic stale = 1'b0;
  // after hold time the line turns over, so a late sample shows up
  assign serialIn = bitReg ^ stale;
  always @(sckLine) begin
    if (sckLine) begin
      stale <= #12 1'b1;
    end else begin
      stale <= 1'b0;
    end
  end
  always @(negedge sckLine or posedge clr) begin
    if (clr) begin
      stream <= txStream;
    end else begin
      bitReg <= stream[0];
      stream <= stream >> 1;
    end
  end
  always @(posedge sckLine or posedge clr) begin
    if (clr) begin
      capWord <= '0;
      capCnt <= '0;
    end else begin
      capWord <= {serialOut, capWord[15:1]};
      capCnt <= capCnt + 5'h01;
    end
  end
endmodule

// ==== tb_ssp_sync_serial.sv ====
/*
  Self-checking bench of the synchronous serial port.
  Assumes ssp_cfg.svh, ssp_pkg and the peripheral model compile first.
*/
`include "ssp_cfg.svh"
module tb_ssp_sync_serial;
  timeunit 1ns;
  timeprecision 1ps;
  import ssp_pkg::*;
  localparam ssp_addr_t addrBuf = `SSP_ADDR_BUF0;
  localparam ssp_addr_t addrMain = `SSP_ADDR_MAIN;
  localparam ssp_addr_t addrCfg = `SSP_ADDR_CFG;
  logic ref_clk, rst, regWr, regRd, dividerAltSelect, slowMode;
  logic sckOut, sckOe, serialOut, serialIn, irq, clr, extSck;
  ssp_addr_t regAddr;
  ssp_byte_t regWdata, regRdata, rd;
  logic [15:0] txStream, capWord;
  logic [4:0] capCnt;
  int errorCnt, numChecks;
  // outside clock idles high and owns the pin only while the port does not drive it
  wire sckLine = sckOe ? sckOut : extSck;
  ssp_sync_serial #(.SLOW_HALF(4)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .dividerAltSelect(dividerAltSelect),
    .slowMode(slowMode), .sckIn(sckLine), .serialIn(serialIn), .sckOut(sckOut),
    .sckOe(sckOe), .serialOut(serialOut), .serialDoneInterrupt(irq));
  ssp_peripheral_model u_peer (.sckLine(sckLine), .serialOut(serialOut), .clr(clr),
    .txStream(txStream), .serialIn(serialIn), .capWord(capWord), .capCnt(capCnt));
  // ----
  // bus and compare tasks
  // ----
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input ssp_addr_t a, input ssp_byte_t d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdc(input string what, input ssp_addr_t a, input ssp_byte_t exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
    check(what, {8'h00, rd}, {8'h00, exp});
  endtask
  task automatic pulseClr(input logic [15:0] s);
    @(posedge ref_clk);
    txStream <= s;
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
  endtask
  // bounded wait; the pulse lasts one cycle, so every cycle is looked at
  task automatic waitIrq(input int lim);
    bit seen;
    seen = 1'b0;
    for (int n = 0; n < lim && !seen; n++) begin
      @(posedge ref_clk);
      #1 seen = (irq === 1'b1);
    end
    check("interrupt", {15'h0, seen}, 16'h0001);
  endtask
  task automatic reportAndStop();
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----
  // clock, watchdog, tests
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    errorCnt++;
    $display("watchdog expired");
    reportAndStop();
  end
  initial begin
    rst = 1'b1;
    regAddr = '0;
    regWdata = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    dividerAltSelect = 1'b0;
    slowMode = 1'b0;
    clr = 1'b0;
    extSck = 1'b1;
    txStream = '0;
    errorCnt = 0;
    numChecks = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rdc("status", addrCfg, 8'h00);
    rdc("unmapped", 12'hF9A, 8'h00);
    wr(addrBuf + 12'h007, 8'h5A);
    rdc("buffer", addrBuf + 12'h007, 8'h5A);
    for (int m = 0; m < 8; m++) begin
      wr(addrMain, {2'b10, 3'(m), 3'b101});
      rdc("start mode", addrCfg, m inside {0, 2, 4, 5, 6} ? 8'hC0 : 8'h00);
      wr(addrMain, {2'b01, 3'(m), 3'b101});
      rdc("abort", addrCfg, 8'h00);
    end
    for (int c = 0; c < 8; c++) begin
      wr(addrMain, {5'b10000, 3'(c)});
      rdc("start clock", addrCfg, c == 6 ? 8'h00 : 8'hC0);
      check("clock enable", {15'h0, sckOe}, {15'h0, c < 6});
      check("clock at start", {15'h0, sckOut}, 16'h0001);
      wr(addrMain, {5'b01000, 3'(c)});
    end
    for (int k = 0; k < 2; k++) begin
      dividerAltSelect <= (k == 0);
      slowMode <= (k == 1);
      pulseClr(16'h0000);
      wr(addrMain, 8'h80);
      repeat (24) @(posedge ref_clk);
      check("slow clock", {15'h0, capCnt >= 5'h02}, 16'h0001);
      wr(addrMain, 8'h40);
    end
    dividerAltSelect <= 1'b0;
    slowMode <= 1'b0;
    wr(addrBuf, 8'hA5);
    wr(addrBuf + 12'h001, 8'h3C);
    wr(addrCfg, 8'h01);
    pulseClr(16'h0000);
    wr(addrMain, 8'h85);
    waitIrq(2000);
    check("tx words", capWord, 16'h3CA5);
    rdc("auto wait", addrCfg, 8'h80);
    wr(addrMain, 8'h45);
    pulseClr(16'h0000);
    wr(addrMain, 8'h95);
    waitIrq(2000);
    check("tx nibbles", {8'h00, capWord[15:8]}, 16'h00C5);
    wr(addrCfg, 8'h00);
    pulseClr(16'h0000);
    wr(addrBuf, 8'h96);
    waitIrq(2000);
    check("resumed", {12'h000, capWord[15:12]}, 16'h0006);
    wr(addrMain, 8'h45);
    rdc("stopped", addrCfg, 8'h00);
    wr(addrCfg, 8'h01);
    pulseClr(16'h00C3);
    wr(addrMain, 8'hB5);
    waitIrq(2000);
    wr(addrMain, 8'h45);
    rdc("rx first", addrBuf, 8'h03);
    rdc("rx second", addrBuf + 12'h001, 8'h0C);
    wr(addrBuf, 8'h81);
    wr(addrCfg, 8'h08);
    pulseClr(16'h005E);
    wr(addrMain, 8'hA5);
    waitIrq(2000);
    wr(addrMain, 8'h45);
    check("txrx out", {8'h00, capWord[15:8]}, 16'h0081);
    rdc("txrx in", addrBuf, 8'h5E);
    wr(addrBuf, 8'h69);
    wr(addrCfg, 8'h00);
    pulseClr(16'h0000);
    wr(addrMain, 8'h87);
    // eight outside pulses, each phase well above the minimum width
    repeat (8) begin
      repeat (8) @(posedge ref_clk);
      extSck <= 1'b0;
      repeat (8) @(posedge ref_clk);
      extSck <= 1'b1;
    end
    repeat (4) @(posedge ref_clk);
    check("ext out", {8'h00, capWord[15:8]}, 16'h0069);
    rdc("ext end", addrCfg, 8'h00);
    reportAndStop();
  end
endmodule
